// ==== logic/efsp_stats_pulses.sv ====
// efsp_stats_pulses: per-frame statistics increment pulses, tx and rx.
// assumes frame summaries come from mac logic on the same clock, so the
// summary inputs are used without synchronisers.
`timescale 1ns/1ps
`default_nettype none

module efsp_stats_pulses (
  input  wire logic                           clock,
  input  wire logic                           rst_n,
  // transmit frame summary
  input  wire logic                           tx_frame_done,
  input  wire logic [efsp_pkg::LEN_W-1:0]     tx_frame_len,
  input  wire logic [efsp_pkg::ADDR_W-1:0]    tx_dest_addr,
  input  wire logic                           tx_fcs_err,
  input  wire logic                           tx_is_ctrl,
  input  wire logic                           tx_is_pause,
  input  wire logic [efsp_pkg::LEN_W-1:0]     tx_max_size,
  // receive frame summary
  input  wire logic                           rx_frame_done,
  input  wire logic [efsp_pkg::LEN_W-1:0]     rx_frame_len,
  input  wire logic [efsp_pkg::ADDR_W-1:0]    rx_dest_addr,
  input  wire logic                           rx_fcs_err,
  input  wire logic                           rx_is_ctrl,
  input  wire logic                           rx_is_pause,
  input  wire logic [efsp_pkg::LEN_W-1:0]     rx_max_size,
  // transmit increments
  output logic                                tx_inc_64,
  output logic                                tx_inc_127,
  output logic                                tx_inc_255,
  output logic                                tx_inc_511,
  output logic                                tx_inc_1023,
  output logic                                tx_inc_1518,
  output logic                                tx_inc_max,
  output logic                                tx_inc_over,
  output logic                                tx_inc_mcast_data_err,
  output logic                                tx_inc_mcast_data_ok,
  output logic                                tx_inc_bcast_data_err,
  output logic                                tx_inc_bcast_data_ok,
  output logic                                tx_inc_ucast_data_err,
  output logic                                tx_inc_ucast_data_ok,
  output logic                                tx_inc_mcast_ctrl,
  output logic                                tx_inc_bcast_ctrl,
  output logic                                tx_inc_ucast_ctrl,
  output logic                                tx_inc_pause,
  output logic                                tx_inc_fcs_err,
  output logic                                tx_inc_fragment,
  output logic                                tx_inc_jabber,
  output logic                                tx_inc_sizeok_fcserr,
  // receive increments
  output logic                                rx_inc_runt,
  output logic                                rx_inc_64,
  output logic                                rx_inc_127,
  output logic                                rx_inc_255,
  output logic                                rx_inc_511,
  output logic                                rx_inc_1023,
  output logic                                rx_inc_1518,
  output logic                                rx_inc_max,
  output logic                                rx_inc_over,
  output logic                                rx_inc_mcast_data_err,
  output logic                                rx_inc_mcast_data_ok,
  output logic                                rx_inc_bcast_data_err,
  output logic                                rx_inc_bcast_data_ok,
  output logic                                rx_inc_ucast_data_err,
  output logic                                rx_inc_ucast_data_ok,
  output logic                                rx_inc_mcast_ctrl,
  output logic                                rx_inc_bcast_ctrl,
  output logic                                rx_inc_ucast_ctrl,
  output logic                                rx_inc_pause,
  output logic                                rx_inc_fcs_err,
  output logic                                rx_inc_fragment,
  output logic                                rx_inc_jabber,
  output logic                                rx_inc_sizeok_fcserr,
  output logic                                rx_inc_pause_ctrl_err,
  output logic                                rx_inc_mcast_ctrl_err,
  output logic                                rx_inc_bcast_ctrl_err,
  output logic                                rx_inc_ucast_ctrl_err,
  // same pulses bundled for the counter block
  output logic      [efsp_pkg::N_CLASS-1:0]   tx_inc_vec,
  output logic      [efsp_pkg::N_CLASS-1:0]   rx_inc_vec
);

  if (efsp_pkg::LEN_W < 11) begin : g_len_chk
    $error("length width too small for the largest size bin");
  end

  ////////////////////////////////////////////////////////////////////////////
  // reset release

  logic rst_sync_n;

  efsp_rst_sync u_rst (
    .clock      (clock),
    .rst_n      (rst_n),
    .rst_sync_n (rst_sync_n)
  );

  ////////////////////////////////////////////////////////////////////////////
  // classification, one instance per direction

  logic [efsp_pkg::N_CLASS-1:0] tx_cls_nxt;
  logic [efsp_pkg::N_CLASS-1:0] rx_cls_nxt;
  logic [efsp_pkg::N_CLASS-1:0] tx_cls_r;
  logic [efsp_pkg::N_CLASS-1:0] rx_cls_r;

  // transmit side logic sees only transmit inputs
  efsp_frame_class #(.RX_SIDE(1'b0)) u_tx_class (
    .frame_done (tx_frame_done),
    .frame_len  (tx_frame_len),
    .max_size   (tx_max_size),
    .dest_addr  (tx_dest_addr),
    .fcs_err    (tx_fcs_err),
    .is_ctrl    (tx_is_ctrl),
    .is_pause   (tx_is_pause),
    .cls        (tx_cls_nxt)
  );

  // receive side logic sees only receive inputs
  efsp_frame_class #(.RX_SIDE(1'b1)) u_rx_class (
    .frame_done (rx_frame_done),
    .frame_len  (rx_frame_len),
    .max_size   (rx_max_size),
    .dest_addr  (rx_dest_addr),
    .fcs_err    (rx_fcs_err),
    .is_ctrl    (rx_is_ctrl),
    .is_pause   (rx_is_pause),
    .cls        (rx_cls_nxt)
  );

  ////////////////////////////////////////////////////////////////////////////
  // pulse registers: one cycle per frame, zero otherwise

  // no counter block gates these; they run in every build
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      tx_cls_r <= efsp_pkg::CLASS_NONE;
      rx_cls_r <= efsp_pkg::CLASS_NONE;
    end else begin
      tx_cls_r <= tx_cls_nxt;
      rx_cls_r <= rx_cls_nxt;
    end
  end

  // ports and counter feed come from the same flops
  assign tx_inc_vec = tx_cls_r;
  assign rx_inc_vec = rx_cls_r;

  ////////////////////////////////////////////////////////////////////////////
  // transmit pulse ports

  // list order must follow the class positions if they ever move
  assign {tx_inc_sizeok_fcserr, tx_inc_jabber, tx_inc_fragment,
          tx_inc_fcs_err, tx_inc_pause, tx_inc_ucast_ctrl,
          tx_inc_bcast_ctrl, tx_inc_mcast_ctrl, tx_inc_ucast_data_ok,
          tx_inc_ucast_data_err, tx_inc_bcast_data_ok,
          tx_inc_bcast_data_err, tx_inc_mcast_data_ok,
          tx_inc_mcast_data_err, tx_inc_over, tx_inc_max, tx_inc_1518,
          tx_inc_1023, tx_inc_511, tx_inc_255, tx_inc_127,
          tx_inc_64} = tx_cls_r[efsp_pkg::C_SZOK:efsp_pkg::C_64];

  ////////////////////////////////////////////////////////////////////////////
  // receive pulse ports

  assign {rx_inc_ucast_ctrl_err, rx_inc_bcast_ctrl_err,
          rx_inc_mcast_ctrl_err, rx_inc_pause_ctrl_err,
          rx_inc_sizeok_fcserr, rx_inc_jabber, rx_inc_fragment,
          rx_inc_fcs_err, rx_inc_pause, rx_inc_ucast_ctrl,
          rx_inc_bcast_ctrl, rx_inc_mcast_ctrl, rx_inc_ucast_data_ok,
          rx_inc_ucast_data_err, rx_inc_bcast_data_ok,
          rx_inc_bcast_data_err, rx_inc_mcast_data_ok,
          rx_inc_mcast_data_err, rx_inc_over, rx_inc_max, rx_inc_1518,
          rx_inc_1023, rx_inc_511, rx_inc_255, rx_inc_127, rx_inc_64,
          rx_inc_runt} = rx_cls_r;

endmodule : efsp_stats_pulses

`default_nettype wire

// ==== logic/efsp_pkg.sv ====
// efsp_pkg: constants shared by the frame statistics pulse generator.
// assumes the MAC delivers one end-of-frame summary per frame per side.
// Operation
// - increment pulses exist always, with or without any counter block
// - every increment pulse leaves as a port and feeds counter logic
// - transmit pulses come from transmit logic, receive from receive logic
// - each sent frame pulses its one size bin, 64 up to 1518 bytes
// - each received frame pulses its one size bin, 64 up to 1518 bytes
// - sent frame equal to programmed transmit maximum pulses max output
// - sent frame above programmed transmit maximum pulses oversize output
// - received frame equal to programmed receive maximum pulses max output
// - received frame above programmed receive maximum pulses oversize
// - sent data frame pulses one of six by address type and health
// - good sent control frame pulses control output of its address type
// - good sent pause frame pulses the transmit pause output
// - sent frame check error pulses one output, and another if size fine
// - sent short crc-bad frame is fragment, oversized crc-bad is jabber
// - received runt packet pulses the receive runt output
// - received data frame pulses one of six by address type and health
// - good received control frame pulses control output of its type
// - good received pause frame pulses the receive pause output
// - received check error pulses one output, another if size fine
// - received short crc-bad is fragment, oversized crc-bad is jabber
// - bad received pause and bad control frames by type pulse outputs

package efsp_pkg;

  localparam int unsigned LEN_W   = 16;
  localparam int unsigned ADDR_W  = 48;
  localparam int unsigned MCAST_BIT = 40;

  // size bin bounds in bytes
  localparam logic [LEN_W-1:0] MIN_FRAME = 16'h0040;
  localparam logic [LEN_W-1:0] BIN_127   = 16'h007F;
  localparam logic [LEN_W-1:0] BIN_255   = 16'h00FF;
  localparam logic [LEN_W-1:0] BIN_511   = 16'h01FF;
  localparam logic [LEN_W-1:0] BIN_1023  = 16'h03FF;
  localparam logic [LEN_W-1:0] BIN_1518  = 16'h05EE;

  localparam logic [ADDR_W-1:0] BCAST_ADDR = 48'hFFFFFFFFFFFF;

  // class vector positions
  localparam int unsigned C_RUNT    = 0;
  localparam int unsigned C_64      = 1;
  localparam int unsigned C_127     = 2;
  localparam int unsigned C_255     = 3;
  localparam int unsigned C_511     = 4;
  localparam int unsigned C_1023    = 5;
  localparam int unsigned C_1518    = 6;
  localparam int unsigned C_MAX     = 7;
  localparam int unsigned C_OVER    = 8;
  localparam int unsigned C_MC_DERR = 9;
  localparam int unsigned C_MC_DOK  = 10;
  localparam int unsigned C_BC_DERR = 11;
  localparam int unsigned C_BC_DOK  = 12;
  localparam int unsigned C_UC_DERR = 13;
  localparam int unsigned C_UC_DOK  = 14;
  localparam int unsigned C_MC_CTRL = 15;
  localparam int unsigned C_BC_CTRL = 16;
  localparam int unsigned C_UC_CTRL = 17;
  localparam int unsigned C_PAUSE   = 18;
  localparam int unsigned C_FCS     = 19;
  localparam int unsigned C_FRAG    = 20;
  localparam int unsigned C_JABBER  = 21;
  localparam int unsigned C_SZOK    = 22;
  localparam int unsigned C_P_CERR  = 23;
  localparam int unsigned C_MC_CERR = 24;
  localparam int unsigned C_BC_CERR = 25;
  localparam int unsigned C_UC_CERR = 26;
  localparam int unsigned N_CLASS   = 27;

  localparam logic [N_CLASS-1:0] CLASS_NONE = 27'h0000000;

  typedef enum logic [1:0] { EFSP_UCAST, EFSP_MCAST, EFSP_BCAST } efsp_dest_e;

  // first octet on the wire sits in the top byte; its lsb is group bit
  function automatic efsp_dest_e dest_type(input logic [ADDR_W-1:0] da);
    if (da == BCAST_ADDR) begin
      return EFSP_BCAST;
    end else if (da[MCAST_BIT]) begin
      return EFSP_MCAST;
    end else begin
      return EFSP_UCAST;
    end
  endfunction : dest_type

endpackage : efsp_pkg

// ==== logic/efsp_rst_sync.sv ====
// efsp_rst_sync: asynchronous assert, synchronous release of reset.
// assumes rst_n may drop at any time relative to clock.
`timescale 1ns/1ps
`default_nettype none

module efsp_rst_sync (
  input  wire logic clock,
  input  wire logic rst_n,
  output var  logic rst_sync_n
);

  logic meta_r;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      meta_r     <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      meta_r     <= 1'b1;
      rst_sync_n <= meta_r;
    end
  end

endmodule : efsp_rst_sync

`default_nettype wire

// ==== logic/efsp_frame_class.sv ====
// efsp_frame_class: combinational classification of one finished frame.
// assumes inputs are stable in the cycle where frame_done is high.
`timescale 1ns/1ps
`default_nettype none

module efsp_frame_class #(
  parameter bit RX_SIDE = 1'b0
) (
  input  wire logic                           frame_done,
  input  wire logic [efsp_pkg::LEN_W-1:0]     frame_len,
  input  wire logic [efsp_pkg::LEN_W-1:0]     max_size,
  input  wire logic [efsp_pkg::ADDR_W-1:0]    dest_addr,
  input  wire logic                           fcs_err,
  input  wire logic                           is_ctrl,
  input  wire logic                           is_pause,
  output logic      [efsp_pkg::N_CLASS-1:0]   cls
);

  function automatic logic in_rng(input logic [efsp_pkg::LEN_W-1:0] v,
                                  input logic [efsp_pkg::LEN_W-1:0] lo,
                                  input logic [efsp_pkg::LEN_W-1:0] hi);
    return (v >= lo) && (v <= hi);
  endfunction : in_rng

  efsp_pkg::efsp_dest_e dtype;
  wire logic short_w = frame_len < efsp_pkg::MIN_FRAME;
  wire logic over_w  = frame_len > max_size;
  wire logic bad_w   = fcs_err | short_w | over_w;
  wire logic ctl_w   = is_ctrl | is_pause;
  wire logic mc_w;
  wire logic bc_w;
  wire logic uc_w;

  assign dtype = efsp_pkg::dest_type(dest_addr);
  assign mc_w  = dtype == efsp_pkg::EFSP_MCAST;
  assign bc_w  = dtype == efsp_pkg::EFSP_BCAST;
  assign uc_w  = dtype == efsp_pkg::EFSP_UCAST;

  always_comb begin
    cls = efsp_pkg::CLASS_NONE;
    if (frame_done) begin
      // a runt is short but arrived with a clean crc; short and bad is fragment
      cls[efsp_pkg::C_RUNT] = RX_SIDE && short_w && !fcs_err;
      cls[efsp_pkg::C_64] = frame_len == efsp_pkg::MIN_FRAME;
      cls[efsp_pkg::C_127] = in_rng(frame_len, efsp_pkg::MIN_FRAME + 16'h0001,
                                    efsp_pkg::BIN_127);
      cls[efsp_pkg::C_255] = in_rng(frame_len, efsp_pkg::BIN_127 + 16'h0001,
                                    efsp_pkg::BIN_255);
      cls[efsp_pkg::C_511] = in_rng(frame_len, efsp_pkg::BIN_255 + 16'h0001,
                                    efsp_pkg::BIN_511);
      cls[efsp_pkg::C_1023] = in_rng(frame_len, efsp_pkg::BIN_511 + 16'h0001,
                                     efsp_pkg::BIN_1023);
      cls[efsp_pkg::C_1518] = in_rng(frame_len, efsp_pkg::BIN_1023 + 16'h0001,
                                     efsp_pkg::BIN_1518);
      cls[efsp_pkg::C_MAX]  = frame_len == max_size;
      cls[efsp_pkg::C_OVER] = over_w;
      // data frames: one of six by address type and health
      cls[efsp_pkg::C_MC_DERR] = !ctl_w && mc_w && bad_w;
      cls[efsp_pkg::C_MC_DOK]  = !ctl_w && mc_w && !bad_w;
      cls[efsp_pkg::C_BC_DERR] = !ctl_w && bc_w && bad_w;
      cls[efsp_pkg::C_BC_DOK]  = !ctl_w && bc_w && !bad_w;
      cls[efsp_pkg::C_UC_DERR] = !ctl_w && uc_w && bad_w;
      cls[efsp_pkg::C_UC_DOK]  = !ctl_w && uc_w && !bad_w;
      cls[efsp_pkg::C_MC_CTRL] = ctl_w && mc_w && !bad_w;
      cls[efsp_pkg::C_BC_CTRL] = ctl_w && bc_w && !bad_w;
      cls[efsp_pkg::C_UC_CTRL] = ctl_w && uc_w && !bad_w;
      cls[efsp_pkg::C_PAUSE]   = is_pause && !bad_w;
      cls[efsp_pkg::C_FCS]     = fcs_err;
      cls[efsp_pkg::C_SZOK] = fcs_err && !short_w && !over_w;
      cls[efsp_pkg::C_FRAG]   = fcs_err && short_w;
      cls[efsp_pkg::C_JABBER] = fcs_err && over_w;
      cls[efsp_pkg::C_P_CERR]  = RX_SIDE && is_pause && bad_w;
      cls[efsp_pkg::C_MC_CERR] = RX_SIDE && ctl_w && mc_w && bad_w;
      cls[efsp_pkg::C_BC_CERR] = RX_SIDE && ctl_w && bc_w && bad_w;
      cls[efsp_pkg::C_UC_CERR] = RX_SIDE && ctl_w && uc_w && bad_w;
    end
  end

endmodule : efsp_frame_class

`default_nettype wire

// ==== tb/efsp_stats_assertions.sv ====
// efsp_stats_assertions: timing checks on the increment pulse outputs.
// assumes frames are offered only once the reset synchroniser has settled.
`timescale 1ns/1ps
`default_nettype none

module efsp_stats_assertions (
  input wire logic                         clock,
  input wire logic                         rst_n,
  input wire logic                         tx_frame_done,
  input wire logic [efsp_pkg::LEN_W-1:0]   tx_frame_len,
  input wire logic                         tx_fcs_err,
  input wire logic [efsp_pkg::LEN_W-1:0]   tx_max_size,
  input wire logic                         rx_frame_done,
  input wire logic [efsp_pkg::LEN_W-1:0]   rx_frame_len,
  input wire logic                         rx_fcs_err,
  input wire logic [efsp_pkg::LEN_W-1:0]   rx_max_size,
  input wire logic                         tx_inc_64,
  input wire logic                         tx_inc_max,
  input wire logic                         tx_inc_over,
  input wire logic                         tx_inc_fragment,
  input wire logic                         rx_inc_runt,
  input wire logic                         rx_inc_jabber,
  input wire logic [efsp_pkg::N_CLASS-1:0] tx_inc_vec,
  input wire logic [efsp_pkg::N_CLASS-1:0] rx_inc_vec
);

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  sequence tx_take;
    tx_frame_done;
  endsequence
  sequence rx_take;
    rx_frame_done;
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  chk_tx_idle_low:
    assert property (!tx_frame_done |=> tx_inc_vec == '0)
    else $error("tx pulse without a frame");
  chk_rx_idle_low:
    assert property (!rx_frame_done |=> rx_inc_vec == '0)
    else $error("rx pulse without a frame");
  chk_tx_max_size:
    assert property (tx_take |=>
      tx_inc_max == ($past(tx_frame_len) == $past(tx_max_size)))
    else $error("tx max pulse wrong");
  chk_tx_over_size:
    assert property (tx_take |=>
      tx_inc_over == ($past(tx_frame_len) > $past(tx_max_size)))
    else $error("tx oversize pulse wrong");
  chk_rx_max_over:
    assert property (rx_take |=>
      rx_inc_vec[efsp_pkg::C_MAX] ==
        ($past(rx_frame_len) == $past(rx_max_size)) &&
      rx_inc_vec[efsp_pkg::C_OVER] ==
        ($past(rx_frame_len) > $past(rx_max_size)))
    else $error("rx max or oversize pulse wrong");
  chk_tx_bin_64:
    assert property (tx_take ##0 tx_frame_len == 16'h0040 |=> tx_inc_64)
    else $error("tx 64 byte bin missed");
  chk_tx_frag_short:
    assert property (tx_take ##0 (tx_fcs_err && tx_frame_len < 16'h0040)
      |=> tx_inc_fragment)
    else $error("tx fragment missed");
  chk_rx_runt_short:
    assert property (rx_take ##0 (!rx_fcs_err && rx_frame_len < 16'h0040)
      |=> rx_inc_runt)
    else $error("rx runt missed");
  chk_rx_jabber_big:
    assert property (rx_take ##0 (rx_fcs_err && rx_frame_len > rx_max_size)
      |=> rx_inc_jabber)
    else $error("rx jabber missed");
  chk_tx_vec_ports:
    assert property (tx_inc_vec[efsp_pkg::C_64] == tx_inc_64
      && tx_inc_vec[efsp_pkg::C_MAX] == tx_inc_max
      && tx_inc_vec[efsp_pkg::C_FRAG] == tx_inc_fragment)
    else $error("tx vector and ports disagree");

endmodule : efsp_stats_assertions

`default_nettype wire

// ==== tb/efsp_cnt_model.sv ====
// efsp_cnt_model: stand-in for the statistics counter block.
// assumes increment vectors are registered one-cycle pulses on clock.
`timescale 1ns/1ps
`default_nettype none

module efsp_cnt_model (
  input  wire logic                         clock,
  input  wire logic                         rst_n,
  input  wire logic [efsp_pkg::N_CLASS-1:0] tx_inc_vec,
  input  wire logic [efsp_pkg::N_CLASS-1:0] rx_inc_vec,
  output var  logic [31:0]                  total
);
  // one running sum of every increment seen on both vectors
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      total <= 32'h00000000;
    end else begin
      total <= total + 32'($countones(tx_inc_vec) + $countones(rx_inc_vec));
    end
  end
endmodule : efsp_cnt_model

`default_nettype wire

// ==== tb/tb.sv ====
// tb: directed frames on both sides, vectors compared against a model.
// assumes one clock for both sides and registered one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic        tx_done = 1'b0, rx_done = 1'b0;
  logic [15:0] tx_len = 16'h0040, rx_len = 16'h0040;
  logic [15:0] tx_max = 16'h05EE, rx_max = 16'h05EE;
  logic [47:0] tx_da = '0, rx_da = '0;
  logic        tx_fcs = 1'b0, rx_fcs = 1'b0, tx_ct = 1'b0, rx_ct = 1'b0;
  logic        tx_pa = 1'b0, rx_pa = 1'b0;
  logic [26:0] tx_vec, rx_vec;
  wire logic [22:1] tp;
  wire logic [26:0] rp;
  logic [31:0] total;
  int          n_mismatch = 0, comparisons = 0;
  logic [31:0] total_exp = 32'h00000000;

  always #5 clock = ~clock;

  efsp_stats_pulses efsp_stats_pulses_i (
    .clock(clock), .rst_n(rst_n),
    .tx_frame_done(tx_done), .tx_frame_len(tx_len), .tx_dest_addr(tx_da),
    .tx_fcs_err(tx_fcs), .tx_is_ctrl(tx_ct), .tx_is_pause(tx_pa),
    .tx_max_size(tx_max), .rx_frame_done(rx_done), .rx_frame_len(rx_len),
    .rx_dest_addr(rx_da), .rx_fcs_err(rx_fcs), .rx_is_ctrl(rx_ct),
    .rx_is_pause(rx_pa), .rx_max_size(rx_max),
    .tx_inc_64(tp[1]), .tx_inc_127(tp[2]), .tx_inc_255(tp[3]),
    .tx_inc_511(tp[4]), .tx_inc_1023(tp[5]), .tx_inc_1518(tp[6]),
    .tx_inc_max(tp[7]), .tx_inc_over(tp[8]),
    .tx_inc_mcast_data_err(tp[9]), .tx_inc_mcast_data_ok(tp[10]),
    .tx_inc_bcast_data_err(tp[11]), .tx_inc_bcast_data_ok(tp[12]),
    .tx_inc_ucast_data_err(tp[13]), .tx_inc_ucast_data_ok(tp[14]),
    .tx_inc_mcast_ctrl(tp[15]), .tx_inc_bcast_ctrl(tp[16]),
    .tx_inc_ucast_ctrl(tp[17]), .tx_inc_pause(tp[18]),
    .tx_inc_fcs_err(tp[19]), .tx_inc_fragment(tp[20]),
    .tx_inc_jabber(tp[21]), .tx_inc_sizeok_fcserr(tp[22]),
    .rx_inc_runt(rp[0]), .rx_inc_64(rp[1]), .rx_inc_127(rp[2]),
    .rx_inc_255(rp[3]), .rx_inc_511(rp[4]), .rx_inc_1023(rp[5]),
    .rx_inc_1518(rp[6]), .rx_inc_max(rp[7]), .rx_inc_over(rp[8]),
    .rx_inc_mcast_data_err(rp[9]), .rx_inc_mcast_data_ok(rp[10]),
    .rx_inc_bcast_data_err(rp[11]), .rx_inc_bcast_data_ok(rp[12]),
    .rx_inc_ucast_data_err(rp[13]), .rx_inc_ucast_data_ok(rp[14]),
    .rx_inc_mcast_ctrl(rp[15]), .rx_inc_bcast_ctrl(rp[16]),
    .rx_inc_ucast_ctrl(rp[17]), .rx_inc_pause(rp[18]),
    .rx_inc_fcs_err(rp[19]), .rx_inc_fragment(rp[20]),
    .rx_inc_jabber(rp[21]), .rx_inc_sizeok_fcserr(rp[22]),
    .rx_inc_pause_ctrl_err(rp[23]), .rx_inc_mcast_ctrl_err(rp[24]),
    .rx_inc_bcast_ctrl_err(rp[25]), .rx_inc_ucast_ctrl_err(rp[26]),
    .tx_inc_vec(tx_vec), .rx_inc_vec(rx_vec));

  efsp_cnt_model efsp_cnt_model_i (.clock(clock), .rst_n(rst_n),
    .tx_inc_vec(tx_vec), .rx_inc_vec(rx_vec), .total(total));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [26:0] exp_vec(input bit rx, input logic [15:0] n,
      input logic [15:0] mx, input logic [47:0] da, input bit f, c, p);
    logic [26:0] v;
    int          k;
    bit          bad;
    v = '0;
    bad = f || n < 16'h0040 || n > mx;
    // k orders destinations as the vector does: multicast, broadcast, unicast
    k = (da == 48'hFFFFFFFFFFFF) ? 1 : (da[40] ? 0 : 2);
    v[efsp_pkg::C_RUNT] = rx && n < 16'h0040 && !f;
    v[efsp_pkg::C_64] = n == 16'h0040;
    v[efsp_pkg::C_127] = n > 16'h0040 && n < 16'h0080;
    v[efsp_pkg::C_255] = n >= 16'h0080 && n < 16'h0100;
    v[efsp_pkg::C_511] = n >= 16'h0100 && n < 16'h0200;
    v[efsp_pkg::C_1023] = n >= 16'h0200 && n < 16'h0400;
    v[efsp_pkg::C_1518] = n >= 16'h0400 && n <= 16'h05EE;
    v[efsp_pkg::C_MAX] = n == mx;
    v[efsp_pkg::C_OVER] = n > mx;
    v[efsp_pkg::C_MC_DERR + 2 * k + int'(!bad)] = !(c || p);
    v[efsp_pkg::C_MC_CTRL + k] = (c || p) && !bad;
    v[efsp_pkg::C_PAUSE] = p && !bad;
    v[efsp_pkg::C_FCS] = f;
    v[efsp_pkg::C_FRAG] = f && n < 16'h0040;
    v[efsp_pkg::C_JABBER] = f && n > mx;
    v[efsp_pkg::C_SZOK] = f && n >= 16'h0040 && n <= mx;
    v[efsp_pkg::C_P_CERR] = rx && p && bad;
    v[efsp_pkg::C_MC_CERR + k] = rx && (c || p) && bad;
    return v;
  endfunction : exp_vec

  task automatic cmp(input logic [31:0] s, e, input string what);
    comparisons++;
    if (s !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, e, s);
    end
  endtask : cmp

  // one frame on one side; pulses are judged in the cycle after the offer
  task automatic frame(input bit rx, input logic [15:0] n,
      input logic [47:0] da, input bit f = 0, c = 0, p = 0);
    logic [26:0] e;
    @(posedge clock);
    #1;
    if (rx) begin
      {rx_done, rx_len, rx_da, rx_fcs, rx_ct, rx_pa} = {1'b1, n, da, f, c, p};
    end else begin
      {tx_done, tx_len, tx_da, tx_fcs, tx_ct, tx_pa} = {1'b1, n, da, f, c, p};
    end
    e = exp_vec(rx, n, rx ? rx_max : tx_max, da, f, c, p);
    @(posedge clock);
    #1;
    {tx_done, rx_done} = 2'b00;
    total_exp += 32'($countones(e));
    cmp(32'(rx ? rx_vec : tx_vec), 32'(e), "pulse vector");
    cmp(32'(rx ? tx_vec : rx_vec), 32'h00000000, "other side vector");
    cmp(32'(|({tp, rp} ^ {tx_vec[22:1], rx_vec})), 32'h0, "ports");
  endtask : frame

  ////////////////////////////////////////////////////////////////////////////
  localparam logic [47:0] UC = 48'h020000000001, MC = 48'h01005E000001;

  task automatic t_bins;
    logic [15:0] lens[11] = '{16'h0040, 16'h0041, 16'h007F, 16'h0080,
      16'h00FF, 16'h0100, 16'h01FF, 16'h0200, 16'h03FF, 16'h0400, 16'h05EE};
    for (int s = 0; s < 2; s++) begin
      foreach (lens[i]) frame(s[0], lens[i], UC);
    end
    $display("test bins done");
  endtask : t_bins

  task automatic t_limits;
    {tx_max, rx_max} = {16'h0100, 16'h0100};
    for (int s = 0; s < 4; s++) begin
      frame(s[0], {15'h0080, s[0]}, MC, s[1]);
      frame(s[0], {15'h0080, ~s[0]}, UC, s[1]);
    end
    {tx_max, rx_max} = {16'h05EE, 16'h05EE};
    $display("test limits done");
  endtask : t_limits

  task automatic t_addr;
    logic [47:0] das[3] = '{UC, MC, 48'hFFFFFFFFFFFF};
    logic [15:0] n = 16'h0080;
    for (int s = 0; s < 2; s++) begin
      foreach (das[i]) begin
        frame(s[0], n, das[i]);
        frame(s[0], n, das[i], 1);
        frame(s[0], n, das[i], 0, 1);
        frame(s[0], n, das[i], 0, 0, 1);
        frame(s[0], n, das[i], 1, 1);
        frame(s[0], n, das[i], 1, 0, 1);
      end
    end
    $display("test addr done");
  endtask : t_addr

  task automatic t_short;
    for (int s = 0; s < 4; s++) begin
      frame(s[0], 16'h003F, UC, s[1]);
    end
    // the counter adds the last pulse one edge after it shows
    @(posedge clock);
    #1;
    cmp(total, total_exp, "counter total");
    $display("test short done");
  endtask : t_short

  task automatic close_out;
    $display("counts: comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : close_out

  initial begin
    repeat (2) @(posedge clock);
    #1;
    rst_n = 1'b1;
    repeat (3) @(posedge clock);
    #1;
    cmp(32'({tx_vec, rx_vec} != '0), 32'h0, "idle vectors");
    t_bins();
    t_limits();
    t_addr();
    t_short();
    close_out();
  end

  // tests need about 150 cycles; the limit is 10000
  initial begin
    #(100000);
    n_mismatch++;
    close_out();
  end
endmodule : tb

bind efsp_stats_pulses efsp_stats_assertions efsp_stats_assertions_i (
  .clock(clock), .rst_n(rst_n), .tx_frame_done(tx_frame_done),
  .tx_frame_len(tx_frame_len), .tx_fcs_err(tx_fcs_err),
  .tx_max_size(tx_max_size), .rx_frame_done(rx_frame_done),
  .rx_frame_len(rx_frame_len), .rx_fcs_err(rx_fcs_err),
  .rx_max_size(rx_max_size), .tx_inc_64(tx_inc_64), .tx_inc_max(tx_inc_max),
  .tx_inc_over(tx_inc_over), .tx_inc_fragment(tx_inc_fragment),
  .rx_inc_runt(rx_inc_runt), .rx_inc_jabber(rx_inc_jabber),
  .tx_inc_vec(tx_inc_vec), .rx_inc_vec(rx_inc_vec));

`default_nettype wire
